// [src/dram_ui_front.sv]
// user-side request front end: command and write-data queues, slot engine, read return
//
// Behaviour
// [RULE_01] command pushed while command queue full is discarded until full drops
// [RULE_02] write data pushed while write-data queue full is discarded until full drops
// [RULE_03] command queue has separate almost-empty and almost-full flags
// [RULE_04] write-data queue has separate almost-empty and almost-full flags
// [RULE_05] per-slot read valid high exactly when read data sits on the bus
// [RULE_06] calibration done rises only after init and calibration both finish
// [RULE_07] user clock runs at a quarter of memory clock; all ports synchronous
// [RULE_08] user reset output is synchronous to the user clock, active high
// [RULE_09] calibration fault asserted whenever calibration reports a failure
// [RULE_10] user never mixes reads and writes within one cycle's slots
// [RULE_11] four slots per cycle for burst two, two slots for burst four
// [RULE_12] slots run in order; read data returns in read command order
// [RULE_13] user accepts read data in any slot position
// [RULE_14] address slot is 20 or 21 bits; bank bits on separate bus
// [RULE_15] user packs slot addresses by burst length, zero-filling unused bits
// [RULE_16] wide burst-four small density: two zero bits above 18-bit address
// [RULE_17] queues accept nothing while user reset is high
// [RULE_18] user pulses command enable one cycle with command, address, bank valid
// [RULE_19] slot code 01 is read, 00 is write
// [RULE_20] write enable, data and mask come in the write command's cycle
// [RULE_21] user captures read data in the cycle its valid bits are high
// [RULE_22] all read valid bits of a return rise together in one cycle
// [RULE_23] slot codes 10 and 11 are idle and skipped
// [RULE_24] masked write bytes are suppressed and not stored
// [RULE_25] user holds off pushes while the matching queue is full
//
// Local design decisions: the APB slave port and the address map.
module dram_ui_front
  import dram_ui_pkg::*;
#(
  parameter int unsigned BURST_LEN = 4,
  parameter int unsigned CK_PER_CLK = 4,
  parameter int unsigned DATA_WIDTH = 36,
  parameter int unsigned DM_WIDTH = 4,
  parameter int unsigned ADDR_WIDTH = 20,
  parameter int unsigned BANK_WIDTH = 4,
  parameter int unsigned QUEUE_DEPTH = 16,
  localparam int unsigned SLOTS = (BURST_LEN == BURST_TWO) ? SLOTS_BL2 : SLOTS_BL4,
  localparam int unsigned WD_W = 2 * CK_PER_CLK * DATA_WIDTH,
  localparam int unsigned WM_W = 2 * CK_PER_CLK * DM_WIDTH,
  localparam int unsigned SD_W = WD_W / SLOTS,
  localparam int unsigned SM_W = WM_W / SLOTS,
  localparam int unsigned CNT_W = $clog2(QUEUE_DEPTH + 1),
  localparam int unsigned PTR_W = $clog2(QUEUE_DEPTH),
  localparam int unsigned SIDX_W = $clog2(SLOTS + 1)
) (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // user requests
  input wire logic user_cmd_en,
  input wire logic [SLOT_CODE_W*SLOTS-1:0] user_cmd,
  input wire logic [SLOTS*ADDR_WIDTH-1:0] user_addr,
  input wire logic [SLOTS*BANK_WIDTH-1:0] user_ba,
  input wire logic user_wr_en,
  input wire logic [WD_W-1:0] user_wr_data,
  input wire logic [WM_W-1:0] write_byte_mask,
  // queue flags
  output logic cmd_q_full,
  output logic cmd_q_empty,
  output logic cmd_q_aempty,
  output logic cmd_q_afull,
  output logic wd_q_full,
  output logic wd_q_empty,
  output logic wd_q_aempty,
  output logic wd_q_afull,
  // read return
  output logic [SLOTS-1:0] user_rd_valid,
  output logic [WD_W-1:0] user_rd_data,
  // status, user clock and reset
  output logic calibration_done,
  output logic calibration_fault,
  output logic user_side_clock,
  output logic user_side_sync_reset,
  output logic user_side_reset_alias,
  // phy status, same clock
  input wire logic phy_init_done,
  input wire logic phy_cal_done,
  input wire logic phy_cal_fail,
  // memory-side slot port, same clock
  output logic mem_req_valid,
  input wire logic mem_req_ready,
  output logic mem_req_write,
  output logic [ADDR_WIDTH-1:0] mem_req_addr,
  output logic [BANK_WIDTH-1:0] mem_req_bank,
  output logic [SD_W-1:0] mem_req_data,
  output logic [SM_W-1:0] mem_req_mask,
  input wire logic mem_rd_valid,
  input wire logic [SD_W-1:0] mem_rd_data
);

  localparam int unsigned CE_W = SLOT_CODE_W * SLOTS + SLOTS * ADDR_WIDTH + SLOTS * BANK_WIDTH;
  localparam int unsigned WE_W = WD_W + WM_W;
  localparam logic [CNT_W-1:0] DEPTH_CNT = CNT_W'(QUEUE_DEPTH);
  localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(QUEUE_DEPTH - 1);
  localparam logic [SIDX_W-1:0] LAST_SLOT = SIDX_W'(SLOTS - 1);

  logic [RST_STAGES-1:0] rst_chain;
  logic [CE_W-1:0] cq_mem [QUEUE_DEPTH];
  logic [WE_W-1:0] wq_mem [QUEUE_DEPTH];
  logic [PTR_W-1:0] cq_wp, cq_rp, wq_wp, wq_rp;
  logic [CNT_W-1:0] cq_cnt, wq_cnt;
  logic cq_push, cq_pop, wq_push, wq_pop;
  logic [THR_W-1:0] cq_ae_thr, cq_af_thr, wq_ae_thr, wq_af_thr;
  logic [DROP_W-1:0] drop_cmd, drop_wd;
  logic apb_wr, apb_mapped, clr_fault, clr_drops;
  eng_state_e state;
  logic [CE_W-1:0] cur_cmd_entry;
  logic [WE_W-1:0] cur_wd_entry;
  logic [SIDX_W-1:0] slot, rd_total, rd_got;
  logic [WD_W-1:0] rd_buf;
  logic [SLOT_CODE_W-1:0] cur_code;
  logic head_has_write, slot_done, fully_masked;

  // counts reads and detects writes among the slots of one entry
  function automatic logic [SIDX_W-1:0] read_count(input logic [CE_W-1:0] e);
    logic [SIDX_W-1:0] n;
    n = '0;
    for (int i = 0; i < SLOTS; i++) begin
      if (e[SLOT_CODE_W*i +: SLOT_CODE_W] == SLOT_READ) n = n + 1'b1;
    end
    return n;
  endfunction

  function automatic logic has_write(input logic [CE_W-1:0] e);
    logic w;
    w = 1'b0;
    for (int i = 0; i < SLOTS; i++) begin
      if (e[SLOT_CODE_W*i +: SLOT_CODE_W] == SLOT_WRITE) w = 1'b1;
    end
    return w;
  endfunction

  // user clock is the block clock, a quarter of the memory clock
  assign user_side_clock = pclk; // RULE_07

  // reset asserts at once and releases on the user clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_chain <= '1;
    end else if (ce) begin
      rst_chain <= {rst_chain[RST_STAGES-2:0], 1'b0}; // RULE_08
    end
  end
  assign user_side_sync_reset = rst_chain[RST_STAGES-1];
  assign user_side_reset_alias = rst_chain[RST_STAGES-1];

  // calibration status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      calibration_done <= 1'b0;
    end else if (ce) begin
      calibration_done <= phy_init_done & phy_cal_done & ~user_side_sync_reset; // RULE_06
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      calibration_fault <= 1'b0;
    end else if (ce) begin
      if (phy_cal_fail) calibration_fault <= 1'b1; // RULE_09
      else if (clr_fault) calibration_fault <= 1'b0;
    end
  end

  // command queue
  assign cq_push = ce & user_cmd_en & ~cmd_q_full & ~user_side_sync_reset; // RULE_01 RULE_17
  assign cmd_q_full = (cq_cnt == DEPTH_CNT);
  assign cmd_q_empty = (cq_cnt == '0);
  assign cmd_q_aempty = ({{(THR_W){1'b0}}, cq_cnt} <= {{(CNT_W){1'b0}}, cq_ae_thr}); // RULE_03
  assign cmd_q_afull = ({{(THR_W){1'b0}}, cq_cnt} >= {{(CNT_W){1'b0}}, cq_af_thr}); // RULE_03

  always_ff @(posedge pclk) begin
    if (cq_push) cq_mem[cq_wp] <= {user_ba, user_addr, user_cmd};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cq_wp <= '0;
      cq_rp <= '0;
      cq_cnt <= '0;
    end else if (ce) begin
      if (cq_push) cq_wp <= (cq_wp == LAST_PTR) ? '0 : cq_wp + 1'b1;
      if (cq_pop) cq_rp <= (cq_rp == LAST_PTR) ? '0 : cq_rp + 1'b1;
      cq_cnt <= cq_cnt + CNT_W'(cq_push) - CNT_W'(cq_pop);
    end
  end

  // write-data queue
  assign wq_push = ce & user_wr_en & ~wd_q_full & ~user_side_sync_reset; // RULE_02 RULE_17
  assign wd_q_full = (wq_cnt == DEPTH_CNT);
  assign wd_q_empty = (wq_cnt == '0);
  assign wd_q_aempty = ({{(THR_W){1'b0}}, wq_cnt} <= {{(CNT_W){1'b0}}, wq_ae_thr}); // RULE_04
  assign wd_q_afull = ({{(THR_W){1'b0}}, wq_cnt} >= {{(CNT_W){1'b0}}, wq_af_thr}); // RULE_04

  always_ff @(posedge pclk) begin
    if (wq_push) wq_mem[wq_wp] <= {write_byte_mask, user_wr_data};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wq_wp <= '0;
      wq_rp <= '0;
      wq_cnt <= '0;
    end else if (ce) begin
      if (wq_push) wq_wp <= (wq_wp == LAST_PTR) ? '0 : wq_wp + 1'b1;
      if (wq_pop) wq_rp <= (wq_rp == LAST_PTR) ? '0 : wq_rp + 1'b1;
      wq_cnt <= wq_cnt + CNT_W'(wq_push) - CNT_W'(wq_pop);
    end
  end

  // pushes discarded while a queue is full are counted for software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drop_cmd <= '0;
      drop_wd <= '0;
    end else if (ce) begin
      if (user_cmd_en & cmd_q_full & ~user_side_sync_reset) drop_cmd <= drop_cmd + 1'b1;
      else if (clr_drops) drop_cmd <= '0;
      if (user_wr_en & wd_q_full & ~user_side_sync_reset) drop_wd <= drop_wd + 1'b1;
      else if (clr_drops) drop_wd <= '0;
    end
  end

  // slot engine: one entry at a time, slots strictly in order
  assign head_has_write = has_write(cq_mem[cq_rp]);
  assign cq_pop = ce & (state == ENG_IDLE) & calibration_done & ~cmd_q_empty
                & (~head_has_write | ~wd_q_empty);
  assign wq_pop = cq_pop & head_has_write; // RULE_20

  assign cur_code = cur_cmd_entry[SLOT_CODE_W*slot +: SLOT_CODE_W];
  assign fully_masked = &cur_wd_entry[WD_W + SM_W*slot +: SM_W];
  assign mem_req_write = (cur_code == SLOT_WRITE); // RULE_19
  assign mem_req_valid = (state == ENG_ISSUE) & ((cur_code == SLOT_READ) // RULE_23
                       | (mem_req_write & ~fully_masked)); // RULE_24
  assign mem_req_addr =
    cur_cmd_entry[SLOT_CODE_W*SLOTS + ADDR_WIDTH*slot +: ADDR_WIDTH]; // RULE_14
  assign mem_req_bank =
    cur_cmd_entry[SLOT_CODE_W*SLOTS + SLOTS*ADDR_WIDTH + BANK_WIDTH*slot +: BANK_WIDTH];
  assign mem_req_data = cur_wd_entry[SD_W*slot +: SD_W];
  assign mem_req_mask = cur_wd_entry[WD_W + SM_W*slot +: SM_W]; // RULE_24
  assign slot_done = (state == ENG_ISSUE) & (~mem_req_valid | mem_req_ready);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ENG_IDLE;
      slot <= '0;
      rd_total <= '0;
      cur_cmd_entry <= '0;
      cur_wd_entry <= '0;
    end else if (ce) begin
      unique case (state)
        ENG_IDLE: begin
          if (cq_pop) begin
            cur_cmd_entry <= cq_mem[cq_rp];
            cur_wd_entry <= head_has_write ? wq_mem[wq_rp] : {WE_W{1'b1}};
            rd_total <= read_count(cq_mem[cq_rp]);
            slot <= '0;
            state <= ENG_ISSUE;
          end
        end
        ENG_ISSUE: begin
          if (slot_done) begin
            if (slot == LAST_SLOT) state <= ENG_RETURN; // RULE_11 RULE_12
            else slot <= slot + 1'b1; // RULE_12
          end
        end
        ENG_RETURN: begin
          if (rd_got == rd_total) state <= ENG_IDLE;
        end
      endcase
    end
  end

  // read return: data packs into low slots in arrival order
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_got <= '0;
    end else if (ce) begin
      if (state == ENG_RETURN && rd_got == rd_total) rd_got <= '0;
      else if (mem_rd_valid && rd_got < LAST_SLOT + 1'b1) rd_got <= rd_got + 1'b1;
    end
  end

  for (genvar g = 0; g < SLOTS; g++) begin : g_rd
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        rd_buf[SD_W*g +: SD_W] <= '0;
        user_rd_valid[g] <= 1'b0;
      end else if (ce) begin
        if (mem_rd_valid && rd_got == SIDX_W'(g)) rd_buf[SD_W*g +: SD_W] <= mem_rd_data; // RULE_12
        user_rd_valid[g] <= (state == ENG_RETURN) && (rd_got == rd_total)
                          && (SIDX_W'(g) < rd_total); // RULE_05 RULE_22
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      user_rd_data <= '0;
    end else if (ce) begin
      if (state == ENG_RETURN && rd_got == rd_total && rd_total != '0)
        user_rd_data <= rd_buf; // RULE_05
    end
  end

  // register bus slave, zero wait states
  assign pready = 1'b1;
  assign apb_mapped = (paddr == REG_THRESH) | (paddr == REG_STATUS)
                    | (paddr == REG_DROPS) | (paddr == REG_CTRL);
  assign pslverr = psel & penable & ~apb_mapped;
  assign apb_wr = ce & psel & penable & pwrite & apb_mapped;
  assign clr_fault = apb_wr & (paddr == REG_CTRL) & pwdata[CTRL_CLR_FAULT];
  assign clr_drops = apb_wr & (paddr == REG_CTRL) & pwdata[CTRL_CLR_DROPS];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cq_ae_thr <= THR_AE_RST;
      cq_af_thr <= THR_AF_RST;
      wq_ae_thr <= THR_AE_RST;
      wq_af_thr <= THR_AF_RST;
    end else if (apb_wr && paddr == REG_THRESH) begin
      cq_ae_thr <= pwdata[THR_CQ_AE_LSB +: THR_W];
      cq_af_thr <= pwdata[THR_CQ_AF_LSB +: THR_W];
      wq_ae_thr <= pwdata[THR_WQ_AE_LSB +: THR_W];
      wq_af_thr <= pwdata[THR_WQ_AF_LSB +: THR_W];
    end
  end

  // read data is captured in the setup cycle and held through the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (ce && psel && !penable) begin
      prdata <= '0;
      unique case (paddr)
        REG_THRESH: begin
          prdata <= {wq_af_thr, wq_ae_thr, cq_af_thr, cq_ae_thr};
        end
        REG_STATUS: begin
          prdata[ST_CAL_DONE] <= calibration_done;
          prdata[ST_CAL_FAULT] <= calibration_fault;
          prdata[ST_CQ_FULL] <= cmd_q_full;
          prdata[ST_CQ_EMPTY] <= cmd_q_empty;
          prdata[ST_WQ_FULL] <= wd_q_full;
          prdata[ST_WQ_EMPTY] <= wd_q_empty;
          prdata[ST_USER_RST] <= user_side_sync_reset;
          prdata[ST_CQ_CNT_LSB +: CNT_W] <= cq_cnt;
          prdata[ST_WQ_CNT_LSB +: CNT_W] <= wq_cnt;
          prdata[ST_ENG_LSB +: 3] <= state;
        end
        REG_DROPS: begin
          prdata[DROP_CMD_LSB +: DROP_W] <= drop_cmd;
          prdata[DROP_WD_LSB +: DROP_W] <= drop_wd;
        end
        default: begin
          prdata <= '0;
        end
      endcase
    end
  end

endmodule

// [src/dram_ui_pkg.sv]
// constants shared by the user-side request front end of the memory controller
package dram_ui_pkg;
  // command slot encodings
  localparam logic [1:0] SLOT_WRITE = 2'h0;
  localparam logic [1:0] SLOT_READ = 2'h1;
  localparam logic [1:0] SLOT_IDLE_A = 2'h2;
  localparam logic [1:0] SLOT_IDLE_B = 2'h3;
  localparam int unsigned SLOT_CODE_W = 2;

  // slots per user clock for each burst length
  localparam int unsigned SLOTS_BL2 = 4;
  localparam int unsigned SLOTS_BL4 = 2;
  localparam int unsigned BURST_TWO = 2;

  // register byte offsets
  localparam int unsigned PADDR_W = 8;
  localparam logic [7:0] REG_THRESH = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_DROPS = 8'h08;
  localparam logic [7:0] REG_CTRL = 8'h0c;

  // threshold register layout and reset values
  localparam int unsigned THR_W = 8;
  localparam int unsigned THR_CQ_AE_LSB = 0;
  localparam int unsigned THR_CQ_AF_LSB = 8;
  localparam int unsigned THR_WQ_AE_LSB = 16;
  localparam int unsigned THR_WQ_AF_LSB = 24;
  localparam logic [7:0] THR_AE_RST = 8'h02;
  localparam logic [7:0] THR_AF_RST = 8'h0e;

  // status register layout
  localparam int unsigned ST_CAL_DONE = 0;
  localparam int unsigned ST_CAL_FAULT = 1;
  localparam int unsigned ST_CQ_FULL = 2;
  localparam int unsigned ST_CQ_EMPTY = 3;
  localparam int unsigned ST_WQ_FULL = 4;
  localparam int unsigned ST_WQ_EMPTY = 5;
  localparam int unsigned ST_USER_RST = 6;
  localparam int unsigned ST_CQ_CNT_LSB = 8;
  localparam int unsigned ST_WQ_CNT_LSB = 16;
  localparam int unsigned ST_ENG_LSB = 24;

  // drop counter layout and control bits
  localparam int unsigned DROP_W = 16;
  localparam int unsigned DROP_CMD_LSB = 0;
  localparam int unsigned DROP_WD_LSB = 16;
  localparam int unsigned CTRL_CLR_FAULT = 0;
  localparam int unsigned CTRL_CLR_DROPS = 1;

  // user reset release delay in user clocks
  localparam int unsigned RST_STAGES = 2;

  typedef enum logic [2:0] {
    ENG_IDLE = 3'b001,
    ENG_ISSUE = 3'b010,
    ENG_RETURN = 3'b100
  } eng_state_e;
endpackage

// [tb/dram_ui_chk.sv]
// concurrent checks on the user-side request front end ports
module dram_ui_chk #(
  parameter int unsigned SLOTS = 2,
  parameter int unsigned ADDR_WIDTH = 20
) (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // queue flags
  input wire logic cmd_q_full,
  input wire logic cmd_q_empty,
  input wire logic cmd_q_aempty,
  input wire logic cmd_q_afull,
  input wire logic wd_q_full,
  input wire logic wd_q_empty,
  input wire logic wd_q_aempty,
  input wire logic wd_q_afull,
  // read return and status
  input wire logic [SLOTS-1:0] user_rd_valid,
  input wire logic calibration_done,
  input wire logic calibration_fault,
  input wire logic user_side_sync_reset,
  input wire logic phy_init_done,
  input wire logic phy_cal_done,
  input wire logic phy_cal_fail,
  // memory-side slot port
  input wire logic mem_req_valid,
  input wire logic mem_req_ready,
  input wire logic mem_req_write,
  input wire logic [ADDR_WIDTH-1:0] mem_req_addr
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence held_req;
    mem_req_valid && $stable(mem_req_addr) && $stable(mem_req_write);
  endsequence
  sequence rd_gone;
    user_rd_valid == '0;
  endsequence
  chk_cal_cause: assert property (
    $rose(calibration_done) |-> $past(phy_init_done && phy_cal_done))
    else $error("calibration done rose without phy completion");
  chk_cal_in_reset: assert property (user_side_sync_reset |-> !calibration_done)
    else $error("calibration done high during user reset");
  chk_fault_set: assert property (phy_cal_fail && ce |=> calibration_fault)
    else $error("calibration fault not raised");
  chk_reset_blocks: assert property (
    user_side_sync_reset |=> cmd_q_empty && wd_q_empty)
    else $error("queue took an entry during user reset");
  chk_cq_flags: assert property (
    (cmd_q_empty |-> cmd_q_aempty && !cmd_q_full)
    and (cmd_q_full |-> cmd_q_afull && !cmd_q_aempty))
    else $error("command queue flags inconsistent");
  chk_wq_flags: assert property (
    (wd_q_empty |-> wd_q_aempty && !wd_q_full) and (wd_q_full |-> wd_q_afull && !wd_q_aempty))
    else $error("write queue flags inconsistent");
  chk_cq_full_drop: assert property (cmd_q_full && !calibration_done |=> cmd_q_full)
    else $error("command queue full dropped without a pop");
  chk_wq_full_drop: assert property (wd_q_full && !calibration_done |=> wd_q_full)
    else $error("write queue full dropped without a pop");
  chk_rd_together: assert property (
    user_rd_valid != '0 |-> (user_rd_valid & (user_rd_valid + 1'b1)) == '0)
    else $error("read valid bits not packed together");
  chk_rd_pulse: assert property (user_rd_valid != '0 |=> rd_gone)
    else $error("read valid longer than one cycle");
  chk_req_held: assert property (mem_req_valid && !mem_req_ready |=> held_req)
    else $error("slot request changed before ready");
  cov_read_return: cover property (user_rd_valid == '1);
endmodule

bind dram_ui_front dram_ui_chk #(.SLOTS(SLOTS), .ADDR_WIDTH(ADDR_WIDTH)) dram_ui_chk_inst (
  .pclk, .presetn, .ce, .cmd_q_full, .cmd_q_empty, .cmd_q_aempty, .cmd_q_afull,
  .wd_q_full, .wd_q_empty, .wd_q_aempty, .wd_q_afull, .user_rd_valid, .calibration_done,
  .calibration_fault, .user_side_sync_reset, .phy_init_done, .phy_cal_done, .phy_cal_fail,
  .mem_req_valid, .mem_req_ready, .mem_req_write, .mem_req_addr);

// [tb/dram_ui_mem_model.sv]
// behavioural memory behind the slot port: alternating prompt and slow answers
module dram_ui_mem_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // slot requests
  input wire logic mem_req_valid,
  output logic mem_req_ready,
  input wire logic mem_req_write,
  input wire logic [19:0] mem_req_addr,
  input wire logic [143:0] mem_req_data,
  input wire logic [15:0] mem_req_mask,
  // read return
  output logic mem_rd_valid,
  output logic [143:0] mem_rd_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [143:0] mem [32];
  logic [143:0] rq [$];
  logic [1:0] stall;
  logic nreq;
  logic gap;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_req_ready <= 1'b0;
      stall <= 2'h0;
      nreq <= 1'b0;
      gap <= 1'b1;
      mem_rd_valid <= 1'b0;
      mem_rd_data <= 144'h0;
      rq.delete();
    end else begin
      mem_req_ready <= mem_req_valid && !mem_req_ready && stall == 2'h0;
      if (mem_req_valid && !mem_req_ready && stall != 2'h0) stall <= stall - 2'h1;
      if (mem_req_valid && mem_req_ready) begin
        nreq <= ~nreq;
        stall <= nreq ? 2'h3 : 2'h0;
        if (mem_req_write) begin
          for (int k = 0; k < 16; k++) begin
            if (!mem_req_mask[k]) mem[mem_req_addr[4:0]][9*k +: 9] <= mem_req_data[9*k +: 9];
          end
        end else begin
          rq.push_back(mem[mem_req_addr[4:0]]);
        end
      end
      gap <= rq.size() == 0;
      if (rq.size() != 0 && !gap) begin
        mem_rd_valid <= 1'b1;
        mem_rd_data <= rq.pop_front();
        gap <= 1'b1;
      end else begin
        mem_rd_valid <= 1'b0;
        // idle return bus toggles so stale data never looks valid
        mem_rd_data <= ~mem_rd_data;
      end
    end
  end
endmodule

// [tb/lowlatency_dram_user_interface_bench.sv]
// self-checking bench for the user-side request front end
module lowlatency_dram_user_interface_bench import dram_ui_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [3:0] c;
    logic [4:0] a0;
    logic [4:0] a1;
    logic [1:0] ev;
    logic [4:0] e0;
    logic [4:0] e1;
  } row_s;
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r, write_byte_mask = 32'h0;
  logic pready, pslverr, e, user_cmd_en = 0, user_wr_en = 0;
  logic [3:0] user_cmd = 4'h0;
  logic [39:0] user_addr = 40'h0;
  logic [7:0] user_ba = 8'h00;
  logic [287:0] user_wr_data = 288'h0, user_rd_data;
  logic cmd_q_full, cmd_q_empty, cmd_q_aempty, cmd_q_afull;
  logic wd_q_full, wd_q_empty, wd_q_aempty, wd_q_afull;
  logic [1:0] user_rd_valid;
  logic calibration_done, calibration_fault, user_side_clock;
  logic user_side_sync_reset, user_side_reset_alias;
  logic phy_init_done = 0, phy_cal_done = 0, phy_cal_fail = 0;
  logic mem_req_valid, mem_req_ready, mem_req_write, mem_rd_valid;
  logic [19:0] mem_req_addr;
  logic [3:0] mem_req_bank;
  logic [143:0] mem_req_data, mem_rd_data, nw;
  logic [15:0] mem_req_mask;
  int bad_count = 0, n_checks = 0;
  row_s rows [5] = '{'{4'h5, 5'd2, 5'd3, 2'h3, 5'd2, 5'd3}, '{4'h9, 5'd4, 5'd0, 2'h1, 5'd4, 5'd0},
    '{4'h7, 5'd0, 5'd5, 2'h1, 5'd5, 5'd0}, '{4'he, 5'd6, 5'd7, 2'h0, 5'd0, 5'd0},
    '{4'h5, 5'd31, 5'd0, 2'h3, 5'd31, 5'd0}};

  dram_ui_front dram_ui_front_inst (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .user_cmd_en, .user_cmd, .user_addr, .user_ba,
    .user_wr_en, .user_wr_data, .write_byte_mask, .cmd_q_full, .cmd_q_empty, .cmd_q_aempty,
    .cmd_q_afull, .wd_q_full, .wd_q_empty, .wd_q_aempty, .wd_q_afull, .user_rd_valid,
    .user_rd_data, .calibration_done, .calibration_fault, .user_side_clock,
    .user_side_sync_reset, .user_side_reset_alias, .phy_init_done, .phy_cal_done,
    .phy_cal_fail, .mem_req_valid, .mem_req_ready, .mem_req_write, .mem_req_addr,
    .mem_req_bank, .mem_req_data, .mem_req_mask, .mem_rd_valid, .mem_rd_data);
  dram_ui_mem_model dram_ui_mem_model_inst (.pclk, .presetn, .mem_req_valid, .mem_req_ready,
    .mem_req_write, .mem_req_addr, .mem_req_data, .mem_req_mask, .mem_rd_valid, .mem_rd_data);

  initial forever #2.5 pclk = ~pclk;

  function automatic logic [143:0] wd(input logic [4:0] a);
    return {9{11'h2d3, a}};
  endfunction
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmpd(input logic [287:0] got, input logic [287:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic push(input logic [3:0] c, input logic [4:0] a0, input logic [4:0] a1,
      input logic w, input logic [287:0] d, input logic [31:0] m);
    @(posedge pclk);
    user_cmd_en <= 1'b1;
    user_cmd <= c;
    user_addr <= {2'b00, 13'h0, a1, 2'b00, 13'h0, a0};
    user_ba <= {3'h0, a1[0], 3'h0, a0[0]};
    user_wr_en <= w;
    user_wr_data <= d;
    write_byte_mask <= m;
    @(posedge pclk);
    user_cmd_en <= 1'b0;
    user_wr_en <= 1'b0;
  endtask
  task automatic wait_rd(input logic [1:0] ev, input logic [287:0] ex, input logic [287:0] m);
    logic [1:0] v;
    v = 2'b00;
    for (int i = 0; i < 80 && v == 2'b00; i++) begin
      @(posedge pclk);
      v = user_rd_valid;
      if (v != 2'b00) cmpd(user_rd_data & m, ex & m);
    end
    cmp32({30'h0, v}, {30'h0, ev});
  endtask

  initial begin
    repeat (12) @(posedge pclk);
    cmp32({30'h0, user_side_reset_alias, user_side_sync_reset}, 32'h3);
    presetn <= 1'b1;
    apb(1'b0, REG_THRESH, 32'h0);
    cmp32(r, {THR_AF_RST, THR_AE_RST, THR_AF_RST, THR_AE_RST});
    apb(1'b0, 8'h10, 32'h0);
    cmp32({r[30:0], e}, 32'h1);
    for (int i = 0; i < 20 && user_side_sync_reset !== 1'b0; i++) @(posedge pclk);
    // one entry more than the queues hold, before calibration lets them drain
    for (int i = 0; i < 17; i++)
      push(4'h0, 5'(2*i), 5'(2*i+1), 1'b1, {wd(5'(2*i+1)), wd(5'(2*i))}, 32'h0);
    cmp32({28'h0, cmd_q_full, cmd_q_afull, wd_q_full, wd_q_afull}, 32'hf);
    apb(1'b0, REG_DROPS, 32'h0);
    cmp32(r, 32'h00010001);
    apb(1'b0, REG_STATUS, 32'h0);
    cmp32(r, 32'h01101014);
    phy_cal_fail <= 1'b1;
    @(posedge pclk);
    phy_cal_fail <= 1'b0;
    repeat (2) @(posedge pclk);
    cmp32({31'h0, calibration_fault}, 32'h1);
    apb(1'b1, REG_CTRL, 32'h1);
    @(posedge pclk);
    cmp32({31'h0, calibration_fault}, 32'h0);
    phy_init_done <= 1'b1;
    repeat (3) @(posedge pclk);
    cmp32({31'h0, calibration_done}, 32'h0);
    phy_cal_done <= 1'b1;
    for (int i = 0; i < 3000 && cmd_q_empty !== 1'b1; i++) @(posedge pclk);
    cmp32({30'h0, cmd_q_empty, wd_q_empty}, 32'h3);
    foreach (rows[k]) begin
      push(rows[k].c, rows[k].a0, rows[k].a1, 1'b0, 288'h0, 32'h0);
      wait_rd(rows[k].ev, {wd(rows[k].e1), wd(rows[k].e0)},
        {{144{rows[k].ev[1]}}, {144{rows[k].ev[0]}}});
    end
    push(4'h5, 5'd6, 5'd7, 1'b0, 288'h0, 32'h0);
    push(4'h5, 5'd8, 5'd9, 1'b0, 288'h0, 32'h0);
    wait_rd(2'h3, {wd(5'd7), wd(5'd6)}, {288{1'b1}});
    wait_rd(2'h3, {wd(5'd9), wd(5'd8)}, {288{1'b1}});
    nw = ~wd(5'd11);
    push(4'h0, 5'd10, 5'd11, 1'b1, {nw, ~wd(5'd10)}, {16'h00ff, 16'hffff});
    push(4'h5, 5'd10, 5'd11, 1'b0, 288'h0, 32'h0);
    wait_rd(2'h3, {nw[143:72], ~nw[71:0], wd(5'd10)}, {288{1'b1}});
    presetn <= 1'b0;
    ce <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    cmp32({30'h0, user_side_sync_reset, calibration_done}, 32'h2);
    ce <= 1'b1;
    for (int i = 0; i < 20 && calibration_done !== 1'b1; i++) @(posedge pclk);
    cmp32({31'h0, calibration_done}, 32'h1);
    final_report;
  end
  initial begin
    repeat (40000) @(posedge pclk);
    bad_count++;
    final_report;
  end
endmodule
